// ==== design/cbo_top.sv ====
`timescale 1ns/1ps
`include "cbo_params.svh"
module cbo_top
(
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic ref_clk_i,
   input wire logic out_enable_n_i,
   input wire logic serial_clock_line_i,
   input wire logic serial_data_line_i,
   output logic serial_data_line_o,
   output logic serial_data_line_oe_n_o,
   output logic [9:0] mem_clk_o,
   output logic [9:0] mem_clk_oe_n_o
);
   cbo_pkg::cbo_state_s_t q_r;
   cbo_pkg::cbo_state_s_t q_nxt;
   logic [29:0] regs_flat;
   logic scl, sda, scl_rise, scl_fall, start_c, stop_c;

   function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic [29:0] flat);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         2'h0: v = flat[7:0] & `CBO_REG0_MASK;
         2'h1: v = flat[15:8] & `CBO_REG1_MASK;
         2'h2: v = flat[23:16] & `CBO_REG2_MASK;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ===========================================
   // Serial port decode
   assign regs_flat = {6'h00, q_r.reg2, q_r.reg1, q_r.reg0};
   assign scl = q_r.scl_sync[1];
   assign sda = q_r.sda_sync[1];
   assign scl_rise = scl & ~q_r.scl_prev;
   assign scl_fall = ~scl & q_r.scl_prev;
   assign start_c = scl & q_r.scl_prev & q_r.sda_prev & ~sda;
   assign stop_c = scl & q_r.scl_prev & ~q_r.sda_prev & sda;

   always_comb
   begin
      logic [9:0] en;
      logic [7:0] nb;
      logic [1:0] rd_nxt;
      logic [7:0] rd_first;
      en = 10'h000;
      nb = 8'h00;
      rd_nxt = (q_r.rd_idx == 2'h2) ? 2'h0 : q_r.rd_idx + 2'h1;
      rd_first = rd_byte(2'h0, regs_flat);
      q_nxt = q_r;
      q_nxt.scl_sync = {q_r.scl_sync[0], serial_clock_line_i};
      q_nxt.sda_sync = {q_r.sda_sync[0], serial_data_line_i};
      q_nxt.ref_sync = {q_r.ref_sync[0], ref_clk_i};
      q_nxt.oe_sync = {q_r.oe_sync[0], out_enable_n_i};
      q_nxt.scl_prev = scl;
      q_nxt.sda_prev = sda;
      nb = {q_r.shift[6:0], sda};
      if (start_c)
      begin
         q_nxt.state = cbo_pkg::ST_RECV;
         q_nxt.bit_cnt = 3'h0;
         q_nxt.byte_idx = 3'h0;
         q_nxt.sda_drive = 1'b0;
      end
      else if (stop_c)
      begin
         q_nxt.state = cbo_pkg::ST_IDLE;
         q_nxt.sda_drive = 1'b0;
      end
      else
      begin
         unique case (q_r.state)
            cbo_pkg::ST_IDLE:
            begin
               q_nxt.sda_drive = 1'b0;
            end
            cbo_pkg::ST_RECV:
            begin
               if (scl_rise)
               begin
                  q_nxt.shift = nb;
                  q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
                  if (q_r.bit_cnt == 3'h7)
                  begin
                     q_nxt.state = cbo_pkg::ST_ACK;
                     if (q_r.byte_idx == 3'h0)
                     begin
                        if (nb == `CBO_ADDR_WR)
                           q_nxt.reading = 1'b0;
                        else if (nb == `CBO_ADDR_RD)
                           q_nxt.reading = 1'b1;
                        else
                           q_nxt.state = cbo_pkg::ST_IGN;
                     end
                     else if (q_r.byte_idx >= 3'h3)
                     begin
                        if (q_r.byte_idx == 3'h3)
                           q_nxt.reg0 = nb & `CBO_REG0_MASK;
                        else if (q_r.byte_idx == 3'h4)
                           q_nxt.reg1 = nb & `CBO_REG1_MASK;
                        else if (q_r.byte_idx == 3'h5)
                           q_nxt.reg2 = nb & `CBO_REG2_MASK;
                     end
                     // Bytes 1 and 2 are command and count: ignored
                  end
               end
            end
            cbo_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  if (!q_r.sda_drive)
                     q_nxt.sda_drive = 1'b1;
                  else
                  begin
                     q_nxt.sda_drive = 1'b0;
                     q_nxt.bit_cnt = 3'h0;
                     if (q_r.byte_idx != 3'h7)
                        q_nxt.byte_idx = q_r.byte_idx + 3'h1;
                     if (q_r.reading)
                     begin
                        q_nxt.state = cbo_pkg::ST_SEND;
                        q_nxt.rd_idx = 2'h0;
                        q_nxt.shift = rd_first;
                        q_nxt.sda_drive = ~rd_first[7];
                     end
                     else
                        q_nxt.state = cbo_pkg::ST_RECV;
                  end
               end
            end
            cbo_pkg::ST_SEND:
            begin
               if (scl_fall)
               begin
                  if (q_r.bit_cnt == 3'h7)
                  begin
                     q_nxt.sda_drive = 1'b0;
                     q_nxt.state = cbo_pkg::ST_MACK;
                  end
                  else
                  begin
                     q_nxt.bit_cnt = q_r.bit_cnt + 3'h1;
                     q_nxt.shift = {q_r.shift[6:0], 1'b0};
                     q_nxt.sda_drive = ~q_r.shift[6];
                  end
               end
            end
            cbo_pkg::ST_MACK:
            begin
               if (scl_rise)
               begin
                  if (sda)
                     q_nxt.state = cbo_pkg::ST_IGN;
                  else
                  begin
                     // Master acked: next byte, wraps past last register
                     q_nxt.bit_cnt = 3'h0;
                     q_nxt.rd_idx = rd_nxt;
                     q_nxt.shift = rd_byte(rd_nxt, regs_flat);
                  end
               end
               else if (scl_fall && q_r.bit_cnt == 3'h0)
               begin
                  q_nxt.state = cbo_pkg::ST_SEND;
                  q_nxt.sda_drive = ~q_r.shift[7];
               end
            end
            cbo_pkg::ST_IGN:
            begin
               q_nxt.sda_drive = 1'b0;
            end
            default:
            begin
               q_nxt.state = cbo_pkg::ST_IDLE;
            end
         endcase
      end

      // ===========================================
      // Glitch-free output gating
      en = {q_r.reg2[7:6], q_r.reg1[7:4], q_r.reg0[3:0]};
      for (int i = 0; i < `CBO_NUM_OUT; i++)
      begin
         if (!q_r.ref_sync[1] && !q_r.clk_out[i])
            q_nxt.gate[i] = en[i];
         q_nxt.clk_out[i] = q_r.ref_sync[1] & q_r.gate[i];
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         q_r <= '0;
         q_r.state <= cbo_pkg::ST_IDLE;
         q_r.scl_sync <= 2'h3;
         q_r.sda_sync <= 2'h3;
         q_r.oe_sync <= 2'h3;
         q_r.scl_prev <= 1'b1;
         q_r.sda_prev <= 1'b1;
         q_r.reg0 <= `CBO_REG0_RST;
         q_r.reg1 <= `CBO_REG1_RST;
         q_r.reg2 <= `CBO_REG2_RST;
         q_r.gate <= 10'h3FF;
      end
      else
         q_r <= q_nxt;
   end

   // ===========================================
   // Pins
   assign serial_data_line_o = 1'b0;
   assign serial_data_line_oe_n_o = ~q_r.sda_drive;
   assign mem_clk_o = q_r.clk_out;
   assign mem_clk_oe_n_o = {`CBO_NUM_OUT{~q_r.oe_sync[1]}};

   // ===========================================
   // Checks
   a_tristate_all: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      !q_r.oe_sync[1] |-> mem_clk_oe_n_o == 10'h3FF)
      else $error("outputs not floated");

   a_stopped_low: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (q_r.gate == 10'h000) |=> mem_clk_o == 10'h000)
      else $error("stopped output toggles");

   a_gate_glitch: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (q_r.gate != $past(q_r.gate)) |-> ($past(q_r.clk_out) & (q_r.gate ^ $past(q_r.gate))) == 10'h000)
      else $error("gate changed while high");

   a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      (q_r.reg0 & ~`CBO_REG0_MASK) == 8'h00 && (q_r.reg1 & ~`CBO_REG1_MASK) == 8'h00
      && (q_r.reg2 & ~`CBO_REG2_MASK) == 8'h00)
      else $error("reserved bit set");

   a_ack_scl_low: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $changed(q_r.sda_drive) && !start_c && !stop_c |-> !scl)
      else $error("data changed with clock high");

   a_start_recv: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      start_c |=> q_r.state == cbo_pkg::ST_RECV && q_r.bit_cnt == 3'h0)
      else $error("start not taken");

   a_stop_idle: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      stop_c |=> q_r.state == cbo_pkg::ST_IDLE && !q_r.sda_drive)
      else $error("stop not taken");

   a_addr_ack: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_RECV && q_r.byte_idx == 3'h0 && q_r.bit_cnt == 3'h7 && scl_rise
      && {q_r.shift[6:0], sda} == `CBO_ADDR_WR && !start_c && !stop_c |=> q_r.state == cbo_pkg::ST_ACK)
      else $error("own address not acked");

   // ===========================================
   // Transfer sequencing and output-enable checks
   a_addr_refuse: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_RECV && q_r.byte_idx == 3'h0 && q_r.bit_cnt == 3'h7 && scl_rise
      && {q_r.shift[6:0], sda} != `CBO_ADDR_WR && {q_r.shift[6:0], sda} != `CBO_ADDR_RD |=> q_r.state == cbo_pkg::ST_IGN)
      else $error("foreign address taken");

   a_ign_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_IGN && !start_c && !stop_c |=> q_r.state == cbo_pkg::ST_IGN)
      else $error("ignored transfer resumed");

   a_ign_quiet: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_IGN |-> !q_r.sda_drive)
      else $error("data driven while ignoring");

   a_idle_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_IDLE |-> !q_r.sda_drive)
      else $error("data driven while idle");

   a_recv_count: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_RECV && scl_rise && !start_c && !stop_c |=> q_r.bit_cnt == $past(q_r.bit_cnt) + 3'h1)
      else $error("bit count not advanced");

   a_ack_low: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_ACK && scl_fall && !q_r.sda_drive |=> q_r.sda_drive)
      else $error("acknowledge not driven");

   a_ack_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_ACK && scl_fall && q_r.sda_drive && !q_r.reading
      |=> q_r.state == cbo_pkg::ST_RECV && !q_r.sda_drive)
      else $error("acknowledge not released");

   a_byte_sat: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.byte_idx == 3'h7 && !start_c |=> q_r.byte_idx == 3'h7)
      else $error("byte index wrapped");

   a_write_reg0: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_RECV && q_r.byte_idx == 3'h3 && q_r.bit_cnt == 3'h7 && scl_rise
      |=> q_r.reg0 == ($past({q_r.shift[6:0], sda}) & `CBO_REG0_MASK))
      else $error("first enable byte not stored");

   a_write_reg1: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_RECV && q_r.byte_idx == 3'h4 && q_r.bit_cnt == 3'h7 && scl_rise
      |=> q_r.reg1 == ($past({q_r.shift[6:0], sda}) & `CBO_REG1_MASK))
      else $error("second enable byte not stored");

   a_reg_write_only: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      {q_r.reg2, q_r.reg1, q_r.reg0} != $past({q_r.reg2, q_r.reg1, q_r.reg0})
      |-> q_r.state == cbo_pkg::ST_ACK && $past(q_r.state) == cbo_pkg::ST_RECV)
      else $error("enable register changed outside a write");

   a_read_first: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_ACK && scl_fall && q_r.sda_drive && q_r.reading
      |=> q_r.state == cbo_pkg::ST_SEND && q_r.sda_drive == ~q_r.shift[7])
      else $error("read byte not started");

   a_send_bit: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_SEND && scl_fall && q_r.bit_cnt != 3'h7 |=> q_r.sda_drive == ~q_r.shift[7])
      else $error("read bit not driven");

   a_send_last: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_SEND && scl_fall && q_r.bit_cnt == 3'h7
      |=> q_r.state == cbo_pkg::ST_MACK && !q_r.sda_drive)
      else $error("data not released for master ack");

   a_mack_next: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_MACK && scl_fall && q_r.bit_cnt == 3'h0
      |=> q_r.state == cbo_pkg::ST_SEND && q_r.sda_drive == ~q_r.shift[7])
      else $error("next read byte not started");

   a_mack_nack: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_MACK && scl_rise && sda |=> q_r.state == cbo_pkg::ST_IGN)
      else $error("master nack not taken");

   a_rd_wrap: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.state == cbo_pkg::ST_MACK && scl_rise && !sda && q_r.rd_idx == 2'h2 |=> q_r.rd_idx == 2'h0)
      else $error("read index not wrapped");

   a_oe_release: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      q_r.oe_sync[1] |-> mem_clk_oe_n_o == 10'h000)
      else $error("outputs floated while enabled");

   // ===========================================
   // Per-output checks
   generate
      for (genvar g = 0; g < `CBO_NUM_OUT; g++)
      begin : g_out
         a_clk_follow: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            q_r.gate[g] |=> q_r.clk_out[g] == $past(q_r.ref_sync[1]))
            else $error("enabled output not following reference");

         a_clk_stop: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            !q_r.gate[g] |=> !q_r.clk_out[g])
            else $error("stopped output not low");

         a_gate_low: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
            q_r.gate[g] != $past(q_r.gate[g]) |-> !$past(q_r.ref_sync[1]) && !$past(q_r.clk_out[g]))
            else $error("output gate changed while high");
      end
   endgenerate
endmodule

// ==== design/cbo_params.svh ====
`ifndef CBO_PARAMS_SVH
`define CBO_PARAMS_SVH
`define CBO_NUM_OUT 10
`define CBO_ADDR_WR 8'hD2
`define CBO_ADDR_RD 8'hD3
`define CBO_REG0_MASK 8'h0F
`define CBO_REG1_MASK 8'hF0
`define CBO_REG2_MASK 8'hC0
`define CBO_REG0_RST 8'h0F
`define CBO_REG1_RST 8'hF0
`define CBO_REG2_RST 8'hC0
`define CBO_NUM_REGS 3
`endif

// ==== design/cbo_pkg.sv ====
package cbo_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RECV = 6'h02,
      ST_ACK = 6'h04,
      ST_SEND = 6'h08,
      ST_MACK = 6'h10,
      ST_IGN = 6'h20
   } cbo_state_t;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic [1:0] ref_sync;
      logic [1:0] oe_sync;
      logic scl_prev;
      logic sda_prev;
      cbo_state_t state;
      logic [2:0] bit_cnt;
      logic [7:0] shift;
      logic [2:0] byte_idx;
      logic reading;
      logic [1:0] rd_idx;
      logic sda_drive;
      logic [7:0] reg0;
      logic [7:0] reg1;
      logic [7:0] reg2;
      logic [9:0] gate;
      logic [9:0] clk_out;
   } cbo_state_s_t;
endpackage

// ==== testbench/cbo_master_model.sv ====
`timescale 1ns/1ps
module cbo_master_model
(
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   // ==========================
   // Idle bus: clock parked high, data released
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end

   // ==========================
   // Bit level, 64 ns serial period
   task automatic put_bit(input logic b);
      sda_low_o = !b;
      #16 scl_o = 1'b1;
      #32 scl_o = 1'b0;
      #16;
   endtask

   task automatic get_bit(output logic b);
      sda_low_o = 1'b0;
      #16 scl_o = 1'b1;
      #16 b = sda_i;
      #16 scl_o = 1'b0;
      #16;
   endtask

   task automatic start();
      sda_low_o = 1'b0;
      scl_o = 1'b1;
      #16 sda_low_o = 1'b1;
      #16 scl_o = 1'b0;
      #16;
   endtask

   task automatic stop();
      sda_low_o = 1'b1;
      #16 scl_o = 1'b1;
      #16 sda_low_o = 1'b0;
      #32;
   endtask

   // ==========================
   // Byte level, MSB first, ninth bit is acknowledge
   task automatic wb(input logic [7:0] d, output logic ack);
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(ack);
   endtask

   task automatic rb(input logic nack, output logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(nack);
   endtask
endmodule

// ==== testbench/tb_clock_buffer_output_enable_ctrl.sv ====
`timescale 1ns/1ps
module tb_clock_buffer_output_enable_ctrl;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic out_en_n = 1'b1;
   logic [2:0] rdiv = 3'h0;
   logic scl;
   logic sda_low;
   logic sda_o;
   logic sda_oe_n;
   logic [9:0] mclk;
   logic [9:0] mclk_oe_n;
   wire logic sda_w;
   int n_errors = 0;
   int cmp_count = 0;

   always #2.5 sys_clk = ~sys_clk;
   // Reference clock, 40 ns period
   always @(negedge sys_clk) rdiv <= rdiv + 3'h1;
   // Open-drain wire with pull-up
   assign sda_w = !(sda_low || (!sda_oe_n && !sda_o));

   cbo_top i_cbo_top (.sys_clk_i(sys_clk), .arst_n_i(arst_n), .ref_clk_i(rdiv[2]), .out_enable_n_i(out_en_n),
      .serial_clock_line_i(scl), .serial_data_line_i(sda_w), .serial_data_line_o(sda_o),
      .serial_data_line_oe_n_o(sda_oe_n), .mem_clk_o(mclk), .mem_clk_oe_n_o(mclk_oe_n));
   cbo_master_model i_cbo_master_model (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w));

   // ==========================
   // Shared helpers
   task automatic chk(input string what, input logic [9:0] e, input logic [9:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic write_regs(input logic [7:0] a, d0, d1, d2, input logic nack_exp);
      logic ack;
      logic [7:0] q [7];
      q = '{a, 8'hC3, 8'h3C, d0, d1, d2, 8'h5A};
      i_cbo_master_model.start();
      for (int k = 0; k < 7; k++)
      begin
         i_cbo_master_model.wb(q[k], ack);
         chk("wr ack", (k == 0) ? nack_exp : 1'b0, ack);
         if (ack)
            break;
      end
      i_cbo_master_model.stop();
   endtask

   task automatic read_regs(input logic [7:0] e0, e1, e2);
      logic ack;
      logic [7:0] d;
      logic [7:0] e [4];
      e = '{e0, e1, e2, e0};
      i_cbo_master_model.start();
      i_cbo_master_model.wb(8'hD3, ack);
      chk("rd ack", 1'b0, ack);
      for (int k = 0; k < 4; k++)
      begin
         i_cbo_master_model.rb(k == 3, d);
         chk("rd byte", e[k], d);
      end
      i_cbo_master_model.stop();
   endtask

   task automatic clocks(input logic [9:0] m);
      logic [9:0] seen;
      seen = 10'h000;
      repeat (16) @(negedge sys_clk);
      repeat (64)
      begin
         @(negedge sys_clk);
         seen = seen | mclk;
      end
      chk("running", m, seen);
   endtask

   // ==========================
   // Scenarios
   task automatic t_defaults();
      clocks(10'h3FF);
      chk("oe_n", 10'h000, mclk_oe_n);
      read_regs(8'h0F, 8'hF0, 8'hC0);
      $display("defaults done");
   endtask

   task automatic t_write();
      write_regs(8'hD2, 8'hFF, 8'hFF, 8'hFF, 1'b0);
      read_regs(8'h0F, 8'hF0, 8'hC0);
      write_regs(8'hD2, 8'h05, 8'h50, 8'h40, 1'b0);
      clocks(10'h155);
      read_regs(8'h05, 8'h50, 8'h40);
      write_regs(8'hD2, 8'h00, 8'h00, 8'h00, 1'b0);
      clocks(10'h000);
      write_regs(8'hD2, 8'h0A, 8'hA0, 8'h80, 1'b0);
      clocks(10'h2AA);
      $display("write done");
   endtask

   task automatic t_refuse();
      write_regs(8'hD4, 8'hFF, 8'hFF, 8'hFF, 1'b1);
      read_regs(8'h0A, 8'hA0, 8'h80);
      $display("refuse done");
   endtask

   task automatic t_tristate();
      out_en_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk("oe_n low pin", 10'h3FF, mclk_oe_n);
      read_regs(8'h0A, 8'hA0, 8'h80);
      @(negedge sys_clk);
      out_en_n = 1'b1;
      clocks(10'h2AA);
      chk("oe_n high pin", 10'h000, mclk_oe_n);
      $display("tristate done");
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // ==========================
   // Main sequence and watchdog
   initial
   begin
      repeat (3) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_defaults();
      t_write();
      t_refuse();
      t_tristate();
      close_out();
   end

   initial
   begin
      #300000;
      n_errors++;
      close_out();
   end
endmodule
